//--- common/idl_pkg.sv
/*
 * Package of the stillness detection block: register indices, field layout,
 * reset values and the encodings of the sequencing mode and enable fields.
 * Assumes a 32-bit Avalon-MM slave with byte addresses (index times four).
 */
package idl_pkg;

	// ----------------------------------------------------------------
	// Bus and data widths
	// ----------------------------------------------------------------
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int IDX_W    = 6;
	localparam int SAMPLE_W = 14;
	localparam int THR_W    = 13;
	localparam int CNT_W    = 16;
	localparam int STAT_W   = 2;

	// ----------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] REG_THR_HIGH_IDX = 6'h23;
	localparam logic [IDX_W-1:0] REG_THR_LOW_IDX  = 6'h24;
	localparam logic [IDX_W-1:0] REG_CNT_HIGH_IDX = 6'h25;
	localparam logic [IDX_W-1:0] REG_CNT_LOW_IDX  = 6'h26;
	localparam logic [IDX_W-1:0] REG_CTL_IDX      = 6'h27;
	localparam logic [IDX_W-1:0] REG_STATUS_IDX   = 6'h30;
	localparam logic [IDX_W-1:0] REG_MASK_IDX     = 6'h31;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int THR_LOW_LSB    = 2;
	localparam int THR_LOW_W      = 6;
	localparam int THR_HIGH_W     = 7;
	localparam int CTL_W          = 6;
	localparam int CTL_MOTION_LSB = 0;
	localparam int CTL_STILL_LSB  = 2;
	localparam int CTL_MODE_LSB   = 4;
	localparam int STAT_MOTION    = 0;
	localparam int STAT_STILL     = 1;
	localparam logic [7:0]  REG_RESET = 8'h00;
	localparam logic [15:0] CNT_SAT   = 16'hFFFF;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DEFAULT     = 2'b00,
		MODE_LINKED      = 2'b01,
		MODE_DEFAULT_ALT = 2'b10,
		MODE_LOOPED      = 2'b11
	} idl_mode_t;

	typedef enum logic [1:0] {
		EN_OFF     = 2'b00,
		EN_ABS     = 2'b01,
		EN_OFF_ALT = 2'b10,
		EN_REF     = 2'b11
	} idl_en_t;

	typedef enum logic {
		SEQ_MOTION = 1'b0,
		SEQ_STILL  = 1'b1
	} idl_seq_t;

	// Decodes an enable field; only 01 and 11 switch detection on.
	function automatic logic idl_en_on(input logic [1:0] field);
		return (field == EN_ABS) || (field == EN_REF);
	endfunction : idl_en_on

endpackage : idl_pkg

//--- verilog/idl_still_cmp.sv
/*
 * Per-axis magnitude comparison against the stillness threshold.
 * Assumes samples and reference are stable while the caller samples the result.
 */
`timescale 1ns/100ps

module idl_still_cmp
	import idl_pkg::*;
(
	input  wire logic signed [2:0][idl_pkg::SAMPLE_W-1:0] smp,       // X, Y, Z samples.
	input  wire logic signed [2:0][idl_pkg::SAMPLE_W-1:0] ref_smp,   // Reference samples.
	input  wire logic                                     use_ref,   // Subtract reference.
	input  wire logic        [idl_pkg::THR_W-1:0]         thr,       // Stillness threshold.
	output logic                                          all_still  // Every axis below threshold.
);
	logic [2:0] axis_still;

	// ----------------------------------------------------------------
	// One comparator per axis
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 3; i++) begin : g_axis
		logic signed [SAMPLE_W:0] diff;
		logic        [SAMPLE_W:0] mag;
		// Difference is one bit wider so a full-scale swing cannot wrap.
		always_comb begin
			diff = $signed({smp[i][SAMPLE_W-1], smp[i]})
				- (use_ref ? $signed({ref_smp[i][SAMPLE_W-1], ref_smp[i]}) : $signed((SAMPLE_W+1)'(0)));
			mag  = diff[SAMPLE_W] ? (SAMPLE_W+1)'(-diff) : diff;
			axis_still[i] = mag < {2'b00, thr}; // R1
		end
	end

	// Stillness needs every axis under the threshold at once.
	assign all_still = &axis_still; // R3

endmodule : idl_still_cmp

//--- verilog/idl_detect_top.sv
/*
 * Stillness detection and activity/stillness sequencing with its register file.
 * Assumes an Avalon-MM master on CLK, samples and activity events from logic
 * on the same clock, and SAMPLE_VALID pulsing once per output sample.
 */
// What this block does
// R1 - Axis still when magnitude below threshold.
// R2 - Threshold low bits 7:2, high 12:6.
// R3 - Event after programmed consecutive all-still samples.
// R4 - Count high byte lower address, low next.
// R5 - Registers reset zero; reserved bits read zero.
// R6 - Modes 00 and 10: both run, host-acknowledged.
// R7 - Auxiliary activity only in default mode.
// R8 - Mode 01: alternate detection, host acknowledges.
// R9 - Mode 11: alternate detection, internal acknowledge.
// R10 - Linked modes need both enables set.
// R11 - Sequencing affects only the acceleration axes.
// R12 - Host uses default mode for free fall.
// R13 - Stillness enable: 01 absolute, 11 referenced.
// R14 - Motion enable: 01 absolute, 11 referenced.
// R15 - Any axis over threshold restarts count.
// R16 - Re-arming restarts the count.
`timescale 1ns/100ps

module idl_detect_top
	import idl_pkg::*;
(
	input  wire logic                                     CLK,                // 100 MHz clock.
	input  wire logic                                     SRST,               // Synchronous reset.
	input  wire logic        [idl_pkg::ADDR_W-1:0]        AVS_ADDRESS,        // Byte address.
	input  wire logic                                     AVS_READ,           // Read request.
	input  wire logic                                     AVS_WRITE,          // Write request.
	input  wire logic        [3:0]                        AVS_BYTEENABLE,     // Byte lanes.
	input  wire logic        [idl_pkg::DATA_W-1:0]        AVS_WRITEDATA,      // Write data.
	output logic             [idl_pkg::DATA_W-1:0]        AVS_READDATA,       // Read data.
	output logic                                          AVS_WAITREQUEST,    // Stall the master.
	input  wire logic                                     SAMPLE_VALID,       // New sample strobe.
	input  wire logic signed [2:0][idl_pkg::SAMPLE_W-1:0] SAMPLE_XYZ,         // X, Y, Z samples.
	input  wire logic                                     MOTION_EVENT_IN,    // Activity detector hit.
	output logic                                          MOTION_ARMED,       // Axis activity armed.
	output logic                                          MOTION_REFERENCED,  // Activity referenced.
	output logic                                          AUX_MOTION_ALLOWED, // Temp/aux activity allowed.
	output logic                                          AUTOSLEEP_ALLOWED,  // Autosleep may run.
	output logic                                          STILL_ARMED,        // Stillness armed.
	output logic                                          STILL_EVENT,        // Stillness detected pulse.
	output logic                                          IRQ                 // Interrupt level.
);
	logic                    ack_q;
	logic [DATA_W-1:0]       rdata_q;
	logic [IDX_W-1:0]        idx;
	logic                    wr_acc, rd_acc;
	logic [THR_LOW_W-1:0]    thr_low_q;
	logic [THR_HIGH_W-1:0]   thr_high_q;
	logic [7:0]              cnt_high_q, cnt_low_q;
	logic [CTL_W-1:0]        ctl_q;
	logic [STAT_W-1:0]       status_q, mask_q;
	logic [THR_W-1:0]        thr;
	logic [CNT_W-1:0]        target;
	logic                    motion_on, still_on, still_ref, linked, looped;
	idl_seq_t                seq_q;
	logic                    still_armed, still_armed_q, rearm;
	logic signed [2:0][SAMPLE_W-1:0] ref_q;
	logic                    ref_valid_q, cmp_valid, all_still;
	logic [CNT_W-1:0]        run_q;
	logic                    still_hit, motion_hit, still_evt_q;

	// ----------------------------------------------------------------
	// Avalon-MM slave: every access waits one cycle, then completes
	// ----------------------------------------------------------------
	assign idx             = AVS_ADDRESS[ADDR_W-1:2];
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
	assign wr_acc          = AVS_WRITE & ack_q & AVS_BYTEENABLE[0];
	assign rd_acc          = AVS_READ & ack_q;
	assign AVS_READDATA    = rdata_q;

	// Acknowledge flop; drops at the accepting edge so requests never merge.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
		end
	end

	// Read data is captured in the waiting cycle; unmapped reads return zero.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			rdata_q <= '0;
		end else if (AVS_READ & ~ack_q) begin
			unique case (idx)
				REG_THR_HIGH_IDX: rdata_q <= DATA_W'({1'b0, thr_high_q}); // R5
				REG_THR_LOW_IDX:  rdata_q <= DATA_W'({thr_low_q, 2'b00}); // R5
				REG_CNT_HIGH_IDX: rdata_q <= DATA_W'(cnt_high_q);
				REG_CNT_LOW_IDX:  rdata_q <= DATA_W'(cnt_low_q);
				REG_CTL_IDX:      rdata_q <= DATA_W'(ctl_q); // R5
				REG_STATUS_IDX:   rdata_q <= DATA_W'(status_q);
				REG_MASK_IDX:     rdata_q <= DATA_W'(mask_q);
				default:          rdata_q <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Writable fields only; reserved bits are never stored.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			thr_low_q  <= THR_LOW_W'(REG_RESET); // R5
			thr_high_q <= THR_HIGH_W'(REG_RESET);
			cnt_high_q <= REG_RESET;
			cnt_low_q  <= REG_RESET;
			ctl_q      <= CTL_W'(REG_RESET);
			mask_q     <= STAT_W'(REG_RESET);
		end else if (wr_acc) begin
			if (idx == REG_THR_LOW_IDX)  thr_low_q  <= AVS_WRITEDATA[THR_LOW_LSB +: THR_LOW_W]; // R2
			if (idx == REG_THR_HIGH_IDX) thr_high_q <= AVS_WRITEDATA[THR_HIGH_W-1:0]; // R2
			if (idx == REG_CNT_HIGH_IDX) cnt_high_q <= AVS_WRITEDATA[7:0]; // R4
			if (idx == REG_CNT_LOW_IDX)  cnt_low_q  <= AVS_WRITEDATA[7:0]; // R4
			if (idx == REG_CTL_IDX)      ctl_q      <= AVS_WRITEDATA[CTL_W-1:0];
			if (idx == REG_MASK_IDX)     mask_q     <= AVS_WRITEDATA[STAT_W-1:0];
		end
	end

	// Assembled threshold and sample count.
	assign thr    = {thr_high_q, thr_low_q}; // R2
	assign target = {cnt_high_q, cnt_low_q}; // R4

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	assign motion_on = idl_en_on(ctl_q[CTL_MOTION_LSB +: 2]); // R14
	assign still_on  = idl_en_on(ctl_q[CTL_STILL_LSB +: 2]); // R13
	assign still_ref = ctl_q[CTL_STILL_LSB +: 2] == EN_REF; // R13
	// Linking only takes hold with both detectors enabled; else default mode.
	assign linked = ctl_q[CTL_MODE_LSB] & motion_on & still_on; // R6 R10
	assign looped = linked & (ctl_q[CTL_MODE_LSB +: 2] == MODE_LOOPED); // R9

	// Armed outputs; only the axis detectors follow the sequence.
	assign still_armed        = still_on & (~linked | (seq_q == SEQ_STILL)); // R8 R11
	assign STILL_ARMED        = still_armed;
	assign MOTION_ARMED       = motion_on & (~linked | (seq_q == SEQ_MOTION)); // R8 R11
	assign MOTION_REFERENCED  = ctl_q[CTL_MOTION_LSB +: 2] == EN_REF; // R14
	assign AUX_MOTION_ALLOWED = motion_on & ~linked; // R7
	assign AUTOSLEEP_ALLOWED  = linked; // R6
	assign motion_hit         = MOTION_EVENT_IN & MOTION_ARMED;

	// ----------------------------------------------------------------
	// Sequencer: activity is looked for first, then stillness
	// ----------------------------------------------------------------
	always_ff @(posedge CLK) begin
		if (SRST) begin
			seq_q <= SEQ_MOTION;
		end else if (~linked) begin
			seq_q <= SEQ_MOTION;
		end else begin
			unique case (seq_q)
				SEQ_MOTION: if (motion_hit) seq_q <= SEQ_STILL; // R8 R9
				SEQ_STILL:  if (still_hit) seq_q <= SEQ_MOTION; // R8 R9
			endcase
		end
	end

	// Arming edge detect.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			still_armed_q <= 1'b0;
		end else begin
			still_armed_q <= still_armed;
		end
	end
	assign rearm = still_armed & ~still_armed_q;

	// ----------------------------------------------------------------
	// Reference capture for referenced stillness
	// ----------------------------------------------------------------
	// The first sample after arming becomes the reference and is not counted.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ref_valid_q <= 1'b0;
			ref_q       <= '0;
		end else if (rearm | ~still_armed) begin
			ref_valid_q <= 1'b0;
		end else if (SAMPLE_VALID & ~ref_valid_q) begin
			ref_valid_q <= 1'b1; // R13
			ref_q       <= SAMPLE_XYZ;
		end
	end

	idl_still_cmp u_cmp (
		.smp       (SAMPLE_XYZ),
		.ref_smp   (ref_q),
		.use_ref   (still_ref),
		.thr       (thr),
		.all_still (all_still)
	);

	// ----------------------------------------------------------------
	// Consecutive still sample counter
	// ----------------------------------------------------------------
	assign cmp_valid = SAMPLE_VALID & still_armed & ~rearm & (~still_ref | ref_valid_q);
	// Fires once when the run reaches the target; a target of zero acts as one.
	assign still_hit = cmp_valid & all_still
		& ((17'(run_q) + 17'd1) == {1'b0, (target == '0) ? CNT_W'(1) : target}); // R3

	always_ff @(posedge CLK) begin
		if (SRST) begin
			run_q <= '0;
		end else if (rearm | ~still_armed) begin
			run_q <= '0; // R16
		end else if (cmp_valid) begin
			if (~all_still) begin
				run_q <= '0; // R15
			end else if (run_q != CNT_SAT) begin
				run_q <= run_q + CNT_W'(1); // R3
			end
		end
	end

	// Registered event pulse.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			still_evt_q <= 1'b0;
		end else begin
			still_evt_q <= still_hit;
		end
	end
	assign STILL_EVENT = still_evt_q;

	// ----------------------------------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------------------------------
	// Looped mode clears itself at the next sample; otherwise a status read
	// clears it. A new event in the clearing cycle wins.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			status_q <= STAT_W'(REG_RESET);
		end else begin
			for (int b = 0; b < STAT_W; b++) begin
				if ((b == STAT_MOTION) ? motion_hit : still_hit) begin
					status_q[b] <= 1'b1;
				end else if (looped & SAMPLE_VALID) begin
					status_q[b] <= 1'b0; // R9
				end else if (~looped & rd_acc & (idx == REG_STATUS_IDX)) begin
					status_q[b] <= 1'b0; // R6 R8
				end
			end
		end
	end
	assign IRQ = |(status_q & mask_q);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_thr_low_write: assert property (@(posedge CLK) disable iff (SRST) // R2
		wr_acc && idx == REG_THR_LOW_IDX |=> thr[5:0] == $past(AVS_WRITEDATA[7:2]))
		else $error("threshold low bits not taken from write data");
	a_cnt_high_write: assert property (@(posedge CLK) disable iff (SRST) // R4
		wr_acc && idx == REG_CNT_HIGH_IDX |=> target[15:8] == $past(AVS_WRITEDATA[7:0]))
		else $error("count high byte not taken from write data");
	a_ctl_reserved_zero: assert property (@(posedge CLK) disable iff (SRST) // R5
		rd_acc && idx == REG_CTL_IDX |-> AVS_READDATA[DATA_W-1:6] == '0)
		else $error("control reserved bits read nonzero");
	a_reset_zero: assert property (@(posedge CLK) // R5
		$past(SRST) |-> target == '0 && thr == '0 && ctl_q == '0)
		else $error("registers not zero after reset");
	a_event_needs_run: assert property (@(posedge CLK) disable iff (SRST) // R3
		STILL_EVENT |-> $past(cmp_valid) && $past(all_still) && $past(run_q) + 1 >= $past(target))
		else $error("stillness event without a full run");
	a_restart_on_motion: assert property (@(posedge CLK) disable iff (SRST) // R15
		cmp_valid && !all_still |=> run_q == '0)
		else $error("run not restarted by an active axis");
	a_restart_on_arm: assert property (@(posedge CLK) disable iff (SRST) // R16
		rearm |=> run_q == '0)
		else $error("run not restarted on arming");
	a_default_both: assert property (@(posedge CLK) disable iff (SRST) // R6
		!ctl_q[CTL_MODE_LSB] && motion_on && still_on |-> MOTION_ARMED && STILL_ARMED && !AUTOSLEEP_ALLOWED)
		else $error("default mode does not run both detectors");
	a_linked_one: assert property (@(posedge CLK) disable iff (SRST) // R8
		linked |-> !(MOTION_ARMED && STILL_ARMED))
		else $error("linked mode armed both detectors");
	a_host_ack_hold: assert property (@(posedge CLK) disable iff (SRST) // R8
		!looped && status_q[STAT_STILL] && !(rd_acc && idx == REG_STATUS_IDX) |=> status_q[STAT_STILL])
		else $error("status cleared without a host read");
	a_loop_self_ack: assert property (@(posedge CLK) disable iff (SRST) // R9
		looped && SAMPLE_VALID && !motion_hit && !still_hit |=> status_q == '0)
		else $error("looped mode did not acknowledge internally");
	a_aux_default: assert property (@(posedge CLK) disable iff (SRST) // R7
		AUX_MOTION_ALLOWED |-> !linked && motion_on)
		else $error("auxiliary activity allowed outside default mode");
	a_off_code: assert property (@(posedge CLK) disable iff (SRST) // R13
		ctl_q[CTL_STILL_LSB +: 2] == EN_OFF_ALT |-> !STILL_ARMED ##1 !STILL_EVENT)
		else $error("stillness armed with enable code 10");
	a_thr_high_write: assert property (@(posedge CLK) disable iff (SRST) // R2
		wr_acc && idx == REG_THR_HIGH_IDX |=> thr[12:6] == $past(AVS_WRITEDATA[6:0]))
		else $error("threshold high bits not taken from write data");
	a_cnt_low_write: assert property (@(posedge CLK) disable iff (SRST) // R4
		wr_acc && idx == REG_CNT_LOW_IDX |=> target[7:0] == $past(AVS_WRITEDATA[7:0]))
		else $error("count low byte not taken from write data");
	a_fallback_default: assert property (@(posedge CLK) disable iff (SRST) // R10
		!(motion_on && still_on) |-> !AUTOSLEEP_ALLOWED && STILL_ARMED == still_on && MOTION_ARMED == motion_on)
		else $error("linking taken without both enables");
	a_link_handover: assert property (@(posedge CLK) disable iff (SRST) // R8
		linked && motion_hit && !(wr_acc && idx == REG_CTL_IDX) |=> STILL_ARMED && !MOTION_ARMED)
		else $error("activity hit did not hand over to stillness");
	a_link_return: assert property (@(posedge CLK) disable iff (SRST) // R9
		linked && still_hit && !(wr_acc && idx == REG_CTL_IDX) |=> MOTION_ARMED && !STILL_ARMED)
		else $error("stillness hit did not hand back to activity");
	a_event_status: assert property (@(posedge CLK) disable iff (SRST) // R3
		still_hit |=> STILL_EVENT && status_q[STAT_STILL])
		else $error("stillness hit lost");
	a_read_clears: assert property (@(posedge CLK) disable iff (SRST) // R6
		!looped && rd_acc && idx == REG_STATUS_IDX && !still_hit |=> !status_q[STAT_STILL])
		else $error("status read did not clear stillness bit");
	a_ref_uncounted: assert property (@(posedge CLK) disable iff (SRST) // R13
		still_ref && SAMPLE_VALID && !ref_valid_q |=> run_q == '0)
		else $error("reference sample was counted");

endmodule : idl_detect_top

//--- tb/idl_host_model.sv
/*
 * Host model: an Avalon-MM master with write and read tasks for the register file.
 * Assumes the testbench scope named testbench holds bad_count and give_verdict.
 */
`timescale 1ns/100ps

module idl_host_model
	import idl_pkg::*;
(
	input  wire logic                       clk,         // Bus clock.
	output logic [idl_pkg::ADDR_W-1:0]      address,     // Byte address.
	output logic                            read,        // Read request.
	output logic                            write,       // Write request.
	output logic [3:0]                      byteenable,  // Byte lanes.
	output logic [idl_pkg::DATA_W-1:0]      writedata,   // Write data.
	input  wire logic [idl_pkg::DATA_W-1:0] readdata,    // Read data.
	input  wire logic                       waitrequest  // Slave stall.
);
	// Idle bus from time zero.
	initial begin
		address = '0;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'h0;
		writedata = '0;
	end

	// Holds the request until waitrequest is seen low, then takes data and releases.
	task automatic finish_req(output logic [DATA_W-1:0] d);
		int n;
		d = '0;
		for (n = 0; n < 64; n++) begin
			@(posedge clk);
			if (waitrequest === 1'b0) begin
				d = readdata;
				break;
			end
		end
		read <= 1'b0;
		write <= 1'b0;
		if (n == 64) begin
			$display("Error bus handshake expected waitrequest 0 seen 1");
			testbench.bad_count++;
			testbench.give_verdict();
		end
	endtask : finish_req

	// One register write; the cleared strobe lands at the accepting edge.
	task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] v, input logic [3:0] be);
		logic [DATA_W-1:0] d;
		@(posedge clk);
		address <= {idx, 2'b00};
		writedata <= {24'h000000, v};
		byteenable <= be;
		write <= 1'b1;
		finish_req(d);
		// Waits to the falling edge so callers see the written value settled.
		@(negedge clk);
	endtask : wr

	// One register read.
	task automatic rd(input logic [IDX_W-1:0] idx, output logic [DATA_W-1:0] d);
		@(posedge clk);
		address <= {idx, 2'b00};
		byteenable <= 4'hF;
		read <= 1'b1;
		finish_req(d);
	endtask : rd
endmodule : idl_host_model

//--- tb/testbench.sv
/*
 * Self-checking testbench of the stillness detection block.
 * Assumes the host model for the bus; samples and motion pulses come from here.
 */
`timescale 1ns/100ps

module testbench;
	import idl_pkg::*;
	logic                        clk, srst, smp_valid, motion_in;
	logic signed [2:0][SAMPLE_W-1:0] smp_xyz;
	logic [ADDR_W-1:0]           addr;
	logic                        rd, wr, wait_req, m_armed, m_ref, aux_ok, sleep_ok, s_armed, s_event, irq;
	logic [3:0]                  be;
	logic [DATA_W-1:0]           wdata, rdata, rv;
	int                          bad_count, samples_checked, still_pulses;
	logic [IDX_W-1:0]            idx_l [5] = '{REG_THR_HIGH_IDX, REG_THR_LOW_IDX, REG_CNT_HIGH_IDX,
	                                           REG_CNT_LOW_IDX, REG_CTL_IDX};
	logic [7:0]                  mask_l [5] = '{8'h7F, 8'hFC, 8'hFF, 8'hFF, 8'h3F};

	idl_host_model host (.clk(clk), .address(addr), .read(rd), .write(wr), .byteenable(be),
		.writedata(wdata), .readdata(rdata), .waitrequest(wait_req));

	idl_detect_top uut (.CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_BYTEENABLE(be), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req),
		.SAMPLE_VALID(smp_valid), .SAMPLE_XYZ(smp_xyz), .MOTION_EVENT_IN(motion_in),
		.MOTION_ARMED(m_armed), .MOTION_REFERENCED(m_ref), .AUX_MOTION_ALLOWED(aux_ok),
		.AUTOSLEEP_ALLOWED(sleep_ok), .STILL_ARMED(s_armed), .STILL_EVENT(s_event), .IRQ(irq));

	// Clock of 10 ns period.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Counts stillness pulses as they stand.
	always @(posedge clk) begin
		if (s_event === 1'b1) still_pulses++;
	end

	// Compares a seen value with the expected one.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("Error %s expected %h seen %h", name, exp, seen);
			bad_count++;
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	// One sample with the same value on all three axes.
	task automatic send(input logic [SAMPLE_W-1:0] v);
		@(posedge clk);
		smp_valid <= 1'b1;
		smp_xyz <= {v, v, v};
		@(posedge clk);
		smp_valid <= 1'b0;
	endtask : send

	// One activity detector pulse, then a settling cycle.
	task automatic pulse_motion();
		@(posedge clk);
		motion_in <= 1'b1;
		@(posedge clk);
		motion_in <= 1'b0;
		@(posedge clk);
	endtask : pulse_motion

	// Main sequence.
	initial begin
		srst = 1'b1;
		smp_valid = 1'b0;
		motion_in = 1'b0;
		smp_xyz = '0;
		bad_count = 0;
		samples_checked = 0;
		still_pulses = 0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		// Reset values, then write ones and read back with reserved bits zero.
		for (int i = 0; i < 5; i++) begin
			host.rd(idx_l[i], rv);
			check("reset value", rv, 32'h0);
			host.wr(idx_l[i], 8'hFF, 4'hF);
			host.rd(idx_l[i], rv);
			check("readback", rv, {24'h0, mask_l[i]});
		end
		host.wr(REG_CNT_LOW_IDX, 8'h55, 4'h0);
		host.rd(REG_CNT_LOW_IDX, rv);
		check("lane off write", rv, 32'hFF);
		host.wr(6'h3F, 8'hAA, 4'hF);
		host.rd(6'h3F, rv);
		check("unmapped", rv, 32'h0);
		$display("TB: registers done");
		// Enable codes in default mode, both fields alike.
		for (int e = 0; e < 4; e++) begin
			host.wr(REG_CTL_IDX, 8'(e * 5), 4'hF);
			check("still armed", s_armed, e[0]);
			check("motion armed", m_armed, e[0]);
			check("referenced", m_ref, e == 3);
		end
		// Every sequencing mode with both enables set.
		for (int m = 0; m < 4; m++) begin
			host.wr(REG_CTL_IDX, 8'h00, 4'hF);
			host.wr(REG_CTL_IDX, 8'(m * 16 + 5), 4'hF);
			check("mode motion", m_armed, 1'b1);
			check("mode still", s_armed, !m[0]);
			check("mode aux", aux_ok, !m[0]);
			check("mode sleep", sleep_ok, m[0]);
		end
		host.wr(REG_CTL_IDX, 8'h11, 4'hF);
		check("fallback sleep", sleep_ok, 1'b0);
		check("fallback aux", aux_ok, 1'b1);
		$display("TB: modes done");
		// Threshold 64 from the high register, count 3, default mode.
		host.wr(REG_THR_HIGH_IDX, 8'h01, 4'hF);
		host.wr(REG_THR_LOW_IDX, 8'h00, 4'hF);
		host.wr(REG_CNT_HIGH_IDX, 8'h00, 4'hF);
		host.wr(REG_CNT_LOW_IDX, 8'h03, 4'hF);
		host.wr(REG_MASK_IDX, 8'h00, 4'hF);
		host.wr(REG_CTL_IDX, 8'h00, 4'hF);
		host.wr(REG_CTL_IDX, 8'h04, 4'hF);
		host.rd(REG_STATUS_IDX, rv);
		still_pulses = 0;
		send(14'h0000);
		send(14'h003F);
		send(14'h3FC0);
		send(14'h3FC1);
		repeat (3) @(posedge clk);
		check("no event", still_pulses, 0);
		send(14'h003F);
		send(14'h3FC1);
		send(14'h003F);
		repeat (3) @(posedge clk);
		check("one event", still_pulses, 1);
		check("irq masked", irq, 1'b0);
		host.wr(REG_MASK_IDX, 8'h02, 4'hF);
		check("irq raised", irq, 1'b1);
		host.rd(REG_STATUS_IDX, rv);
		check("status", rv, 32'h2);
		@(posedge clk);
		check("irq cleared", irq, 1'b0);
		$display("TB: stillness done");
		// Linked mode: activity hit hands over to stillness, host clears.
		host.wr(REG_CTL_IDX, 8'h00, 4'hF);
		host.wr(REG_CTL_IDX, 8'h15, 4'hF);
		pulse_motion();
		check("linked motion", m_armed, 1'b0);
		check("linked still", s_armed, 1'b1);
		host.rd(REG_STATUS_IDX, rv);
		check("linked status", rv, 32'h1);
		host.rd(REG_STATUS_IDX, rv);
		check("linked cleared", rv, 32'h0);
		// Looped mode: read leaves status, next sample clears it.
		host.wr(REG_CTL_IDX, 8'h00, 4'hF);
		host.wr(REG_CTL_IDX, 8'h35, 4'hF);
		pulse_motion();
		check("looped still", s_armed, 1'b1);
		host.rd(REG_STATUS_IDX, rv);
		host.rd(REG_STATUS_IDX, rv);
		check("looped held", rv, 32'h1);
		send(14'h0000);
		host.rd(REG_STATUS_IDX, rv);
		check("looped acked", rv, 32'h0);
		send(14'h003F);
		send(14'h3FC1);
		@(posedge clk);
		check("looped back", m_armed, 1'b1);
		check("looped back still", s_armed, 1'b0);
		$display("TB: sequencing done");
		// Referenced stillness: the first sample is the reference and is not counted.
		host.wr(REG_CTL_IDX, 8'h00, 4'hF);
		host.wr(REG_CTL_IDX, 8'h0C, 4'hF);
		still_pulses = 0;
		send(14'h0400);
		send(14'h043F);
		send(14'h03C1);
		send(14'h043F);
		repeat (3) @(posedge clk);
		check("referenced event", still_pulses, 1);
		$display("TB: referenced done");
		give_verdict();
	end
endmodule : testbench
